// ==== inertial_delta_regs.svh ====
// Register indices, reset values and timing counts for the delta integrator.
// Assumes a 100 MHz mclk; included by bare name wherever a constant is needed.
`ifndef INERTIAL_DELTA_REGS_SVH
`define INERTIAL_DELTA_REGS_SVH

// Printed register indices; the APB byte address is four times the index
`define IDX_X_ANGLE_STEP_LOW 8'h24
`define IDX_X_ANGLE_STEP_HIGH 8'h26
`define IDX_Y_ANGLE_STEP_LOW 8'h28
`define IDX_Y_ANGLE_STEP_HIGH 8'h2A
`define IDX_Z_ANGLE_STEP_LOW 8'h2C
`define IDX_Z_ANGLE_STEP_HIGH 8'h2E
`define IDX_X_SPEED_STEP_LOW 8'h30
`define IDX_X_SPEED_STEP_HIGH 8'h32
`define IDX_DECIMATION_SETTING 8'h3C
`define BYTE_ADDR_SHIFT 2

// Reset values
`define DECIMATION_SETTING_RESET 16'h0000
`define RESULT_RESET 32'h00000000

// Result memory entries
`define ENTRY_X_ANGLE 3'h0
`define ENTRY_Y_ANGLE 3'h1
`define ENTRY_Z_ANGLE 3'h2
`define ENTRY_X_SPEED 3'h3
`define ENTRY_Y_SPEED 3'h4
`define ENTRY_Z_SPEED 3'h5
`define ENTRY_LAST 3'h5

// Timing
`define CLK_PERIOD_NS 10
`define SAMPLE_RATE_SPS 2000
`define SAMPLE_PERIOD_NS (1000000000 / `SAMPLE_RATE_SPS)
`define SAMPLE_PERIOD_CYCLES (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ==== inertial_delta_pkg.sv ====
// Types shared by the delta integrator and its result memory.
// Assumes nothing beyond a SystemVerilog compiler.
package inertial_delta_pkg;

  localparam int CHANNELS = 6;

  typedef logic signed [31:0] sample_t;
  typedef logic signed [31:0] result_t;
  typedef logic signed [32:0] pair_t;
  typedef logic signed [49:0] acc_t;
  typedef logic [2:0] entry_t;

  typedef enum logic {ST_RUN, ST_STORE} store_state_e;

  typedef struct packed {
    logic hit;
    entry_t entry;
    logic high;
  } reg_map_s;

endpackage

// ==== result_mem_if.sv ====
// Carrier between the integrator and its result memory.
// One write port and one read port, both on mclk.
interface result_mem_if;
  logic we;
  inertial_delta_pkg::entry_t waddr;
  inertial_delta_pkg::result_t wdata;
  logic re;
  inertial_delta_pkg::entry_t raddr;
  inertial_delta_pkg::result_t rdata;

  modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

// ==== result_mem.sv ====
// Six-entry result memory holding whole 32-bit delta results.
// Assumes one writer and one reader on the same clock; read data is registered.
`include "inertial_delta_regs.svh"

module result_mem
(
  input wire logic mclk,
  input wire logic rst_n,
  result_mem_if.mem port
);

  inertial_delta_pkg::result_t store [0:inertial_delta_pkg::CHANNELS-1];

  // Array is not reset; the integrator writes zeros right after reset
  always_ff @(posedge mclk)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      port.rdata <= `RESULT_RESET;
    end
    else if (port.re)
    begin
      port.rdata <= store[port.raddr];
    end
  end

endmodule // result_mem

// ==== inertial_delta_integrator.sv ====
// Trapezoid delta angle and delta velocity integrator with an APB register slave.
// Assumes samples are held steady on the inputs between internal sample ticks,
// and that APB signals are synchronous to mclk.
//
// The implementer's own choice: register access over APB.
`include "inertial_delta_regs.svh"

module inertial_delta_integrator
#(
  parameter int unsigned TICK_CYCLES = `SAMPLE_PERIOD_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [31:0] gyro_x,
  input wire logic [31:0] gyro_y,
  input wire logic [31:0] gyro_z,
  input wire logic [31:0] accel_x,
  input wire logic [31:0] accel_y,
  input wire logic [31:0] accel_z
);

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

  // Map a byte address onto a memory entry and half
  function automatic inertial_delta_pkg::reg_map_s decode_addr(input logic [11:0] addr);
    inertial_delta_pkg::reg_map_s m;
    m = '0;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[9:2])
        `IDX_X_ANGLE_STEP_LOW: m = '{1'b1, `ENTRY_X_ANGLE, 1'b0};
        `IDX_X_ANGLE_STEP_HIGH: m = '{1'b1, `ENTRY_X_ANGLE, 1'b1};
        `IDX_Y_ANGLE_STEP_LOW: m = '{1'b1, `ENTRY_Y_ANGLE, 1'b0};
        `IDX_Y_ANGLE_STEP_HIGH: m = '{1'b1, `ENTRY_Y_ANGLE, 1'b1};
        `IDX_Z_ANGLE_STEP_LOW: m = '{1'b1, `ENTRY_Z_ANGLE, 1'b0};
        `IDX_Z_ANGLE_STEP_HIGH: m = '{1'b1, `ENTRY_Z_ANGLE, 1'b1};
        `IDX_X_SPEED_STEP_LOW: m = '{1'b1, `ENTRY_X_SPEED, 1'b0};
        `IDX_X_SPEED_STEP_HIGH: m = '{1'b1, `ENTRY_X_SPEED, 1'b1};
        default: m = '0;
      endcase
    end
    if (addr[11:10] != 2'h0)
    begin
      m = '0;
    end
    return m;
  endfunction

  // Halve and clamp a wide trapezoid sum into 32-bit two's complement
  function automatic inertial_delta_pkg::result_t clamp_half(input inertial_delta_pkg::acc_t s);
    inertial_delta_pkg::acc_t h;
    h = s >>> 1;
    if (h > 50'sh0_0000_7FFF_FFFF)
    begin
      return 32'h7FFFFFFF;
    end
    else if (h < -50'sh0_0000_8000_0000)
    begin
      return 32'h80000000;
    end
    else
    begin
      return h[31:0];
    end
  endfunction

  result_mem_if mem_bus ();

  result_mem u_mem
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .port(mem_bus.mem)
  );

  // Sample tick
  logic [16:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 17'h00000;
    end
    else if (tick)
    begin
      tick_cnt <= 17'h00000;
    end
    else
    begin
      tick_cnt <= tick_cnt + 17'h00001;
    end
  end

  // Decimation register
  logic [15:0] decimation_setting;
  logic [15:0] period_last;
  logic [15:0] period_cnt;
  logic period_end;

  // Channel order follows the memory entries: angles first, then velocities
  inertial_delta_pkg::sample_t sample [0:inertial_delta_pkg::CHANNELS-1];
  inertial_delta_pkg::sample_t prev [0:inertial_delta_pkg::CHANNELS-1];
  inertial_delta_pkg::acc_t acc [0:inertial_delta_pkg::CHANNELS-1];
  inertial_delta_pkg::acc_t total [0:inertial_delta_pkg::CHANNELS-1];
  inertial_delta_pkg::result_t res [0:inertial_delta_pkg::CHANNELS-1];

  assign sample[0] = gyro_x;
  assign sample[1] = gyro_y;
  assign sample[2] = gyro_z;
  assign sample[3] = accel_x;
  assign sample[4] = accel_y;
  assign sample[5] = accel_z;

  assign period_end = tick && (period_cnt == period_last);

  genvar ch;
  generate
    for (ch = 0; ch < inertial_delta_pkg::CHANNELS; ch++)
    begin : g_chan
      inertial_delta_pkg::pair_t pair;
      // Current plus previous sample, widened before the add
      assign pair = {sample[ch][31], sample[ch]} + {prev[ch][31], prev[ch]};
      assign total[ch] = acc[ch] + {{17{pair[32]}}, pair};
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      period_cnt <= 16'h0000;
      period_last <= `DECIMATION_SETTING_RESET;
    end
    else if (period_end)
    begin
      period_cnt <= 16'h0000;
      // New setting takes hold only at a period boundary
      period_last <= decimation_setting;
    end
    else if (tick)
    begin
      period_cnt <= period_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < inertial_delta_pkg::CHANNELS; i++)
      begin
        prev[i] <= 32'h00000000;
        acc[i] <= 50'h0;
        res[i] <= `RESULT_RESET;
      end
    end
    else if (tick)
    begin
      for (int i = 0; i < inertial_delta_pkg::CHANNELS; i++)
      begin
        prev[i] <= sample[i];
        if (period_end)
        begin
          acc[i] <= 50'h0;
          // Unit-free 32-bit span; the range variant only scales the samples
          res[i] <= clamp_half(total[i]);
        end
        else
        begin
          acc[i] <= total[i];
        end
      end
    end
  end

  // Store burst: one whole 32-bit entry per cycle keeps halves coherent
  inertial_delta_pkg::store_state_e state;
  inertial_delta_pkg::entry_t wr_idx;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      // Clears the memory after reset so no read returns unknowns
      state <= inertial_delta_pkg::ST_STORE;
      wr_idx <= 3'h0;
    end
    else
    begin
      case (state)
        inertial_delta_pkg::ST_RUN:
        begin
          if (period_end)
          begin
            state <= inertial_delta_pkg::ST_STORE;
            wr_idx <= 3'h0;
          end
        end
        inertial_delta_pkg::ST_STORE:
        begin
          if (wr_idx == `ENTRY_LAST)
          begin
            state <= inertial_delta_pkg::ST_RUN;
          end
          else
          begin
            wr_idx <= wr_idx + 3'h1;
          end
        end
        default:
        begin
          state <= inertial_delta_pkg::ST_RUN;
        end
      endcase
    end
  end

  assign mem_bus.we = (state == inertial_delta_pkg::ST_STORE);
  assign mem_bus.waddr = wr_idx;
  assign mem_bus.wdata = res[wr_idx];

  // APB slave
  inertial_delta_pkg::reg_map_s map;
  logic access;
  logic is_dec;
  logic rd_pending;
  logic mem_read;

  assign map = decode_addr(paddr);
  assign access = psel && penable;
  assign is_dec = (paddr == 12'({`IDX_DECIMATION_SETTING, 2'h0}));
  // Reads of result words wait out a store burst so they never see a half-written set
  assign mem_read = access && !pwrite && map.hit && !rd_pending &&
                    (state == inertial_delta_pkg::ST_RUN);
  assign mem_bus.re = mem_read;
  assign mem_bus.raddr = map.entry;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rd_pending <= 1'b0;
    end
    else if (rd_pending)
    begin
      rd_pending <= 1'b0;
    end
    else if (mem_read)
    begin
      rd_pending <= 1'b1;
    end
  end

  always_comb
  begin
    if (!pwrite && map.hit)
    begin
      pready = access && rd_pending;
    end
    else
    begin
      pready = access;
    end
  end

  always_comb
  begin
    prdata = 32'h00000000;
    if (map.hit)
    begin
      prdata = map.high ? {16'h0000, mem_bus.rdata[31:16]} : {16'h0000, mem_bus.rdata[15:0]};
    end
    else if (is_dec)
    begin
      prdata = {16'h0000, decimation_setting};
    end
  end

  // Writes to result words are refused; they hold no writable state
  assign pslverr = access && pready && (pwrite ? !is_dec : !(is_dec || map.hit));

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      decimation_setting <= `DECIMATION_SETTING_RESET;
    end
    else if (access && pwrite && is_dec)
    begin
      decimation_setting <= pwdata[15:0];
    end
  end

endmodule // inertial_delta_integrator

// ==== inertial_delta_integrator_asserts.sv ====
// APB-side checks of the delta integrator, bound to its top module.
// Assumes one clock, mclk, and the synchronous active-low rst_n.
module inertial_delta_integrator_asserts
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic res;
  logic sel;
  logic [15:0] dec;
  assign acc = psel && penable && pready;
  assign res = paddr >= 12'h090 && paddr <= 12'h0C8 && paddr[2:0] == 3'h0;
  assign sel = paddr == 12'h0F0;
  // Shadow of the setting, so readback is tied to the write that caused it
  always_ff @(posedge mclk)
    if (!rst_n)
      dec <= 16'h0000;
    else if (acc && pwrite && sel)
      dec <= pwdata[15:0];
  a_write_no_wait: assert property (psel && penable && pwrite |-> pready)
    else $error("write access waited");
  a_write_refused: assert property (acc && pwrite && !sel |-> pslverr)
    else $error("write to read-only word accepted");
  a_setting_write: assert property (acc && pwrite && sel |-> !pslverr)
    else $error("setting write refused");
  a_unmapped_read: assert property (acc && !pwrite && !res && !sel |-> pslverr && prdata == 0)
    else $error("unmapped read not refused");
  a_result_wait: assert property (psel && $rose(penable) && !pwrite && res |-> !pready)
    else $error("result read without wait state");
  a_read_bounded: assert property (psel && penable && !pwrite && !pready |-> ##[1:8] pready)
    else $error("read answer too late");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_setting_back: assert property (acc && !pwrite && sel |-> prdata == {16'h0000, dec})
    else $error("setting readback wrong");
  a_result_ok: assert property (acc && !pwrite && res |-> !pslverr)
    else $error("result read refused");
endmodule // inertial_delta_integrator_asserts

// ==== apb_host_model.sv ====
// APB master standing in for the host processor.
// Assumes mclk is the slave's clock; each request starts after a rising edge.
module apb_host_model
(
  input wire logic mclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // Released address and data lines show the inverse of their last value, never a stale copy
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Ready, data and error are all taken at the rising edge that completes the access
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // apb_host_model

// ==== inertial_delta_integrator_test.sv ====
// Self-checking bench: register access, result formats, decimation and clamping.
// Assumes apb_host_model as the host and a shortened sample tick.
module inertial_delta_integrator_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TICK = 16;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [31:0] s [6];
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int tests_run = 0;

  always #5 mclk = ~mclk;

  inertial_delta_integrator #(.TICK_CYCLES(TICK)) u_inertial_delta_integrator (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .gyro_x(s[0]), .gyro_y(s[1]), .gyro_z(s[2]),
    .accel_x(s[3]), .accel_y(s[4]), .accel_z(s[5]));

  apb_host_model u_apb_host_model (
    .mclk(mclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input logic eerr);
    u_apb_host_model.xfer(w, a, d, rd, er);
    if (!w)
      compare(rd, exp);
    compare({31'h0, er}, {31'h0, eerr});
  endtask

  task automatic step_chk(input logic [11:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0, {16'h0000, exp[15:0]}, 1'b0);
    access(1'b0, a + 12'h008, 32'h0, {16'h0000, exp[31:16]}, 1'b0);
  endtask

  task automatic t_access;
    access(1'b0, 12'h0F0, 32'h0, 32'h0, 1'b0);
    access(1'b1, 12'h098, 32'h1234, 32'h0, 1'b1);
    access(1'b0, 12'h098, 32'h0, 32'h0, 1'b0);
    access(1'b0, 12'h094, 32'h0, 32'h0, 1'b1);
    access(1'b0, 12'h092, 32'h0, 32'h0, 1'b1);
    access(1'b1, 12'h0F0, 32'hFFFF0001, 32'h0, 1'b0);
    access(1'b0, 12'h0F0, 32'h0, 32'h00000001, 1'b0);
    // Host runs at decimation zero, as it would to measure the ready rate
    access(1'b1, 12'h0F0, 32'h0, 32'h0, 1'b0);
    $display("test access done");
  endtask

  task automatic t_formats;
    // Long enough for a stray two-tick period to pass before the checks
    repeat (8 * TICK) @(posedge mclk);
    step_chk(12'h090, 32'h00000001);
    step_chk(12'h0A0, 32'hFFFFFFFF);
    step_chk(12'h0B0, 32'h7FFFFFFF);
    step_chk(12'h0C0, 32'h80000000);
    $display("test formats done");
  endtask

  task automatic t_decim;
    access(1'b1, 12'h0F0, 32'h3, 32'h0, 1'b0);
    @(posedge mclk);
    s[0] <= 32'h00000005;
    s[1] <= 32'hFFFFFFFD;
    s[3] <= 32'hC0000000;
    repeat (12 * TICK) @(posedge mclk);
    step_chk(12'h090, 32'h00000014);
    step_chk(12'h0A0, 32'hFFFFFFF4);
    step_chk(12'h0B0, 32'h7FFFFFFF);
    step_chk(12'h0C0, 32'h80000000);
    $display("test decimation done");
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    s[0] = 32'h00000001;
    s[1] = 32'hFFFFFFFF;
    s[2] = 32'h7FFFFFFF;
    s[3] = 32'h80000000;
    s[4] = 32'h00000000;
    s[5] = 32'h00000000;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_access();
    t_formats();
    t_decim();
    finish_test();
  end

  // Tests need about 420 cycles; twelve times that means a hang
  initial
  begin
    repeat (5000) @(posedge mclk);
    failures++;
    finish_test();
  end
endmodule // inertial_delta_integrator_test

bind inertial_delta_integrator inertial_delta_integrator_asserts u_inertial_delta_integrator_asserts (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
